// *** hw/aju_pkg.sv ***
// Shared constants and types for the arithmetic, jump and scale unit
package aju_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 48;
  localparam int ADDR_W = 15;
  localparam int K_W = 12;
  localparam int RET_LSB = 24;
  localparam logic [47:0] WORD_ZERO = 48'h0000_0000_0000;
  localparam logic [47:0] WORD_ONES = 48'hFFFF_FFFF_FFFF;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_STORE_ACC = 6'h10;
  localparam logic [5:0] OP_STORE_AUX = 6'h11;
  localparam logic [5:0] OP_ACC_JUMP = 6'h12;
  localparam logic [5:0] OP_AUX_JUMP = 6'h13;
  localparam logic [5:0] OP_MUL_INT = 6'h14;
  localparam logic [5:0] OP_DIV_INT = 6'h15;
  localparam logic [5:0] OP_MUL_FRAC = 6'h16;
  localparam logic [5:0] OP_DIV_FRAC = 6'h17;
  localparam logic [5:0] OP_FLT_ADD = 6'h18;
  localparam logic [5:0] OP_FLT_SUB = 6'h19;
  localparam logic [5:0] OP_FLT_MUL = 6'h1A;
  localparam logic [5:0] OP_FLT_DIV = 6'h1B;
  localparam logic [5:0] OP_NORM_ACC = 6'h1C;
  localparam logic [5:0] OP_NORM_DBL = 6'h1D;

  // ----------------------------------------------------------------
  // Floating-point packing
  // ----------------------------------------------------------------
  localparam int EXP_LSB = 36;
  localparam logic signed [13:0] EXP_BIAS = 14'sh0400;
  localparam logic signed [13:0] EXP_MAX = 14'sh07FF;
  localparam logic [35:0] COEF_MSB_ONLY = 36'h8_0000_0000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_CMD = 16'h0000;
  localparam logic [15:0] REG_STATUS = 16'h0004;
  localparam logic [15:0] REG_CTRL = 16'h0008;
  localparam logic [15:0] REG_NEXT_STEP = 16'h000C;
  localparam logic [15:0] REG_NEXT_ADDR = 16'h0010;
  localparam logic [15:0] REG_ACC_LO = 16'h0020;
  localparam logic [15:0] REG_ACC_HI = 16'h0024;
  localparam logic [15:0] REG_AUX_LO = 16'h0028;
  localparam logic [15:0] REG_AUX_HI = 16'h002C;
  localparam logic [10:0] REG_INDEX_PAGE = 11'h002;
  localparam logic [3:0] MEM_PAGE = 4'h1;
  localparam int CMD_DES_LSB = 6;
  localparam int CMD_M_LSB = 9;
  localparam int STAT_BUSY = 0;
  localparam int STAT_JUMP = 1;
  localparam int STAT_DIV_OVF = 2;
  localparam int STAT_RANGE = 3;
  localparam int CTRL_SEL_DIV = 0;
  localparam int CTRL_SEL_RANGE = 1;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SCALE} aju_state_t;
endpackage

// *** hw/aju_arith_jump_scale.sv ***
// Arithmetic, register jump and scale datapath with a Wishbone register slave
// Behaviour
// - Store accumulator to execution address, unchanged
// - Store auxiliary register to execution address, unchanged
// - Accumulator jump/return jump on four conditions
// - Negative zero counts as zero in jumps
// - Designator selects condition; jumps never indexed
// - Auxiliary jump/return jump on zero, nonzero, positive, negative
// - Integer multiply, high half auxiliary, low accumulator
// - Integer divide, quotient accumulator, signed remainder
// - Divide overflow sets flag, interrupt when selected
// - Fraction multiply into accumulator-high pair
// - Fraction divide, quotient accumulator, signed remainder
// - Floating add, rounded sum, residue auxiliary
// - Floating subtract, rounded difference, residue auxiliary
// - Floating multiply, rounded product, residue auxiliary
// - Floating divide, rounded quotient, residue auxiliary
// - Exponent overflow/underflow sets range fault flag
// - Normalize accumulator, one rotate per count step
// - Stop at zero count; write count back
// - Same normalize over accumulator/auxiliary pair
// - Scale leaves shift fault indicator alone
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module aju_arith_jump_scale #(
  parameter int MEM_WORDS = 64
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic INTERRUPT_REQ,
  output logic BUSY
);
  localparam int AW = $clog2(MEM_WORDS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aju_pkg::aju_state_t state, next_state;
  logic [47:0] acc, aux;
  logic [47:0] mem [MEM_WORDS];
  logic [14:0] idx [0:7];
  logic [5:0] op;
  logic [2:0] des;
  logic [14:0] m_fld, next_step, next_addr;
  logic [11:0] kcnt;
  logic jump_taken, div_ovf, range_flt, sel_ovf, sel_rng;

  // Byte-lane merge of write data over the current register view
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Magnitude of a ones' complement word
  function automatic logic [47:0] mag(input logic [47:0] w);
    return w[47] ? ~w : w;
  endfunction

  // Floating op: returns {range fault, residue word, result word}
  function automatic logic [96:0] float_op(input logic [1:0] fop, input logic [47:0] a,
                                           input logic [47:0] b);
    logic sa, sb, sx, sy, sr, rng, found;
    logic [47:0] ma, mb, res;
    logic [35:0] fa, fb, coef;
    logic [10:0] ea, eb, sh;
    logic [71:0] x, y;
    logic [72:0] r;
    logic [107:0] q;
    logic [36:0] rc;
    logic signed [13:0] e;
    logic [6:0] lz;
    sa = a[47];
    sb = b[47] ^ (fop == 2'd1);
    ma = mag(a);
    mb = mag(b);
    ea = ma[46:36];
    eb = mb[46:36];
    fa = ma[35:0];
    fb = mb[35:0];
    rng = 1'b0;
    sr = sa ^ sb;
    r = '0;
    e = '0;
    case (fop)
      2'd0, 2'd1: begin
        // Align smaller exponent, keep 36 guard bits for the residue
        if (ea >= eb) begin
          sh = ea - eb;
          x = {fa, 36'h0_0000_0000};
          y = (sh > 11'd72) ? '0 : ({fb, 36'h0_0000_0000} >> sh);
          sx = sa;
          sy = sb;
          e = $signed({3'b000, ea}) + 14'sh0001;
        end else begin
          sh = eb - ea;
          x = {fb, 36'h0_0000_0000};
          y = (sh > 11'd72) ? '0 : ({fa, 36'h0_0000_0000} >> sh);
          sx = sb;
          sy = sa;
          e = $signed({3'b000, eb}) + 14'sh0001;
        end
        if (sx == sy) begin
          r = {1'b0, x} + {1'b0, y};
          sr = sx;
        end else if (x >= y) begin
          r = {1'b0, x - y};
          sr = sx;
        end else begin
          r = {1'b0, y - x};
          sr = sy;
        end
      end
      2'd2: begin
        r = {1'b0, 72'(fa) * 72'(fb)}; // Widened so the product is not cut to 36 bits
        e = $signed({3'b000, ea}) + $signed({3'b000, eb}) - aju_pkg::EXP_BIAS + 14'sh0001;
      end
      default: begin
        // Zero divisor or oversized quotient is a range fault
        q = (fb == '0) ? '0 : ({fa, 72'h00_0000_0000_0000_0000} / {72'h0, fb});
        rng = (fb == '0) || (q[107:73] != '0);
        r = q[72:0];
        e = $signed({3'b000, ea}) - $signed({3'b000, eb}) + aju_pkg::EXP_BIAS + 14'sh0001;
      end
    endcase
    lz = '0;
    found = 1'b0;
    for (int i = 72; i >= 0; i--) begin
      if (!found && !r[i]) begin
        lz = lz + 7'd1;
      end else begin
        found = 1'b1;
      end
    end
    r = r << lz;
    e = e - $signed({7'b000_0000, lz});
    rc = {1'b0, r[72:37]} + {36'h0_0000_0000, r[36]};
    if (rc[36]) begin
      coef = aju_pkg::COEF_MSB_ONLY;
      e = e + 14'sh0001;
    end else begin
      coef = rc[35:0];
    end
    if (r == '0) begin
      res = aju_pkg::WORD_ZERO;
    end else begin
      rng = rng || (e < 14'sh0000) || (e > aju_pkg::EXP_MAX);
      res = {1'b0, e[10:0], coef};
      res = sr ? ~res : res;
    end
    return {rng, 12'h000, r[36:1], res};
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire idle = (state == aju_pkg::ST_IDLE);
  wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire bus_wr = bus_req & WB_WE_I;
  wire reg_wr = bus_wr & idle;
  wire hit_cmd = (WB_ADR_I == aju_pkg::REG_CMD);
  wire hit_stat = (WB_ADR_I == aju_pkg::REG_STATUS);
  wire hit_ctrl = (WB_ADR_I == aju_pkg::REG_CTRL);
  wire hit_step = (WB_ADR_I == aju_pkg::REG_NEXT_STEP);
  wire hit_naddr = (WB_ADR_I == aju_pkg::REG_NEXT_ADDR);
  wire hit_acc_lo = (WB_ADR_I == aju_pkg::REG_ACC_LO);
  wire hit_acc_hi = (WB_ADR_I == aju_pkg::REG_ACC_HI);
  wire hit_aux_lo = (WB_ADR_I == aju_pkg::REG_AUX_LO);
  wire hit_aux_hi = (WB_ADR_I == aju_pkg::REG_AUX_HI);
  wire [2:0] bus_b = WB_ADR_I[4:2];
  wire hit_idx = (WB_ADR_I[15:5] == aju_pkg::REG_INDEX_PAGE) && (bus_b != 3'd0)
                 && (bus_b != 3'd7);
  wire hit_mem = (WB_ADR_I[15:12] == aju_pkg::MEM_PAGE)
                 && ({23'h0, WB_ADR_I[11:3]} < MEM_WORDS);
  wire [AW-1:0] bus_mi = WB_ADR_I[AW+2:3];
  wire [47:0] bus_mw = mem[bus_mi];
  wire [31:0] stat_view = {28'h000_0000, range_flt, div_ovf, jump_taken, ~idle};
  wire [31:0] rd_data =
    hit_stat ? stat_view :
    hit_ctrl ? {30'h0000_0000, sel_rng, sel_ovf} :
    hit_step ? {17'h0_0000, next_step} :
    hit_naddr ? {17'h0_0000, next_addr} :
    hit_acc_lo ? acc[31:0] :
    hit_acc_hi ? {16'h0000, acc[47:32]} :
    hit_aux_lo ? aux[31:0] :
    hit_aux_hi ? {16'h0000, aux[47:32]} :
    hit_idx ? {17'h0_0000, idx[bus_b]} :
    hit_mem ? (WB_ADR_I[2] ? {16'h0000, bus_mw[47:32]} : bus_mw[31:0]) :
    32'h0000_0000;
  wire [31:0] wr_merged = lane_merge(rd_data, WB_DAT_I, WB_SEL_I);
  wire cmd_wr = reg_wr & hit_cmd;
  wire stat_wr = bus_wr & hit_stat;

  // ----------------------------------------------------------------
  // Operand fetch; jumps use m as is, other ops add the index
  // ----------------------------------------------------------------
  wire [14:0] idx_val = (des == 3'd0 || des == 3'd7) ? aju_pkg::ADDR_ZERO : idx[des];
  wire [14:0] exec_addr = m_fld + idx_val;
  wire [AW-1:0] mem_idx = exec_addr[AW-1:0];
  wire [AW-1:0] jmp_idx = m_fld[AW-1:0];
  wire [47:0] operand = mem[mem_idx];
  wire [47:0] jmp_word = mem[jmp_idx];

  // Jump test, both zeros count as zero
  wire [47:0] jreg = (op == aju_pkg::OP_AUX_JUMP) ? aux : acc;
  wire j_zero = (jreg == aju_pkg::WORD_ZERO) || (jreg == aju_pkg::WORD_ONES);
  wire j_neg = jreg[47] & ~j_zero;
  wire is_jump = (op == aju_pkg::OP_ACC_JUMP) || (op == aju_pkg::OP_AUX_JUMP);
  // Designator low bits pick the test, bit 2 the return form; 7 too
  wire j_cond = (des[1:0] == 2'd0) ? j_zero :
                (des[1:0] == 2'd1) ? ~j_zero :
                (des[1:0] == 2'd2) ? ~j_neg : j_neg;

  // Shared magnitude multiplier for both multiplies
  wire [47:0] acc_mag = mag(acc);
  wire [47:0] opd_mag = mag(operand);
  wire [93:0] mul_p = acc_mag[46:0] * opd_mag[46:0];
  wire mul_neg = acc[47] ^ operand[47];
  wire [95:0] mul_int = mul_neg ? ~{2'b00, mul_p} : {2'b00, mul_p};
  wire [95:0] mul_frac = mul_neg ? ~{1'b0, mul_p, 1'b0} : {1'b0, mul_p, 1'b0};

  // Shared divider; fractions divide by twice the divisor to keep the point
  wire div_frac = (op == aju_pkg::OP_DIV_FRAC);
  wire [95:0] dvd = div_frac ? {acc, aux} : {aux, acc};
  wire dvd_neg = dvd[95];
  wire [95:0] dvd_mag = dvd_neg ? ~dvd : dvd;
  wire [46:0] dsr_mag = opd_mag[46:0];
  wire [47:0] den = div_frac ? {dsr_mag, 1'b0} : {1'b0, dsr_mag};
  wire [47:0] den_safe = (den == '0) ? 48'h0000_0000_0001 : den;
  wire [94:0] quo = dvd_mag[94:0] / den_safe;
  wire [94:0] rem_full = dvd_mag[94:0] % den_safe;
  wire [46:0] rem = div_frac ? rem_full[47:1] : rem_full[46:0];
  wire div_bad = (den == '0) || (quo[94:47] != '0);
  wire [47:0] quo_w = (dvd_neg ^ operand[47]) ? ~{1'b0, quo[46:0]} : {1'b0, quo[46:0]};
  wire [47:0] rem_w = dvd_neg ? ~{1'b0, rem} : {1'b0, rem};
  wire [96:0] flt = float_op(op[1:0], acc, operand);

  // Scale helpers
  wire is_scale = (op == aju_pkg::OP_NORM_ACC) || (op == aju_pkg::OP_NORM_DBL);
  wire normed = acc[47] != acc[46];
  wire scale_done = (kcnt == '0) || normed;
  wire [47:0] acc_rot = {acc[46:0], acc[47]};
  wire [95:0] dbl_rot = {acc[46:0], aux, acc[47]};

  // ----------------------------------------------------------------
  // Execute step next values
  // ----------------------------------------------------------------
  logic [47:0] next_acc, next_aux, mem_wd;
  logic [AW-1:0] mem_wa;
  logic mem_we, ovf_evt, rng_evt, next_jump;
  logic [14:0] next_target;
  always_comb begin
    next_acc = acc;
    next_aux = aux;
    mem_we = 1'b0;
    mem_wa = mem_idx;
    mem_wd = operand;
    ovf_evt = 1'b0;
    rng_evt = 1'b0;
    next_jump = 1'b0;
    next_target = next_step;
    case (op)
      aju_pkg::OP_STORE_ACC: begin
        mem_we = 1'b1;
        mem_wd = acc;
      end
      aju_pkg::OP_STORE_AUX: begin
        mem_we = 1'b1;
        mem_wd = aux;
      end
      aju_pkg::OP_ACC_JUMP, aju_pkg::OP_AUX_JUMP: begin
        next_jump = j_cond;
        if (j_cond && des[2]) begin
          mem_we = 1'b1;
          mem_wa = jmp_idx;
          mem_wd = {jmp_word[47:39], next_step, jmp_word[23:0]};
          next_target = m_fld + 15'h0001;
        end else if (j_cond) begin
          next_target = m_fld;
        end
      end
      aju_pkg::OP_MUL_INT: begin
        {next_aux, next_acc} = mul_int;
      end
      aju_pkg::OP_MUL_FRAC: begin
        {next_acc, next_aux} = mul_frac;
      end
      aju_pkg::OP_DIV_INT, aju_pkg::OP_DIV_FRAC: begin
        // Overflow leaves both registers as they were
        ovf_evt = div_bad;
        if (!div_bad) begin
          next_acc = quo_w;
          next_aux = rem_w;
        end
      end
      aju_pkg::OP_FLT_ADD, aju_pkg::OP_FLT_SUB,
      aju_pkg::OP_FLT_MUL, aju_pkg::OP_FLT_DIV: begin
        {rng_evt, next_aux, next_acc} = flt;
      end
      default: begin
      end
    endcase
  end

  // Sequencer: command starts an execute step, scale then iterates
  always_comb begin
    next_state = state;
    case (state)
      aju_pkg::ST_IDLE: if (cmd_wr) next_state = aju_pkg::ST_EXEC;
      aju_pkg::ST_EXEC: next_state = is_scale ? aju_pkg::ST_SCALE : aju_pkg::ST_IDLE;
      aju_pkg::ST_SCALE: if (scale_done) next_state = aju_pkg::ST_IDLE;
      default: next_state = aju_pkg::ST_IDLE;
    endcase
  end

  // Sticky flags: a new event wins over a same-cycle clear
  wire next_div_ovf = (state == aju_pkg::ST_EXEC && ovf_evt)
                      | (div_ovf & ~(stat_wr & WB_DAT_I[aju_pkg::STAT_DIV_OVF]));
  wire next_rng = (state == aju_pkg::ST_EXEC && rng_evt)
                  | (range_flt & ~(stat_wr & WB_DAT_I[aju_pkg::STAT_RANGE]));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Bus slave answers one cycle after the request
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

  // Control, flags and interrupt line
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= aju_pkg::ST_IDLE;
      BUSY <= 1'b0;
      div_ovf <= 1'b0;
      range_flt <= 1'b0;
      INTERRUPT_REQ <= 1'b0;
      sel_ovf <= 1'b0;
      sel_rng <= 1'b0;
    end else begin
      state <= next_state;
      BUSY <= (next_state != aju_pkg::ST_IDLE);
      div_ovf <= next_div_ovf;
      range_flt <= next_rng;
      INTERRUPT_REQ <= (next_div_ovf & sel_ovf) | (next_rng & sel_rng);
      if (bus_wr && hit_ctrl) begin
        sel_ovf <= wr_merged[aju_pkg::CTRL_SEL_DIV];
        sel_rng <= wr_merged[aju_pkg::CTRL_SEL_RANGE];
      end
    end
  end

  // Command latch, program step and jump result
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      op <= 6'h00;
      des <= 3'h0;
      m_fld <= aju_pkg::ADDR_ZERO;
      next_step <= aju_pkg::ADDR_ZERO;
      next_addr <= aju_pkg::ADDR_ZERO;
      jump_taken <= 1'b0;
    end else begin
      if (cmd_wr) begin
        op <= wr_merged[5:0];
        des <= wr_merged[aju_pkg::CMD_DES_LSB +: 3];
        m_fld <= wr_merged[aju_pkg::CMD_M_LSB +: 15];
        jump_taken <= 1'b0;
      end else if (state == aju_pkg::ST_EXEC) begin
        next_addr <= next_target;
        jump_taken <= is_jump & next_jump;
      end
      if (reg_wr && hit_step) begin
        next_step <= wr_merged[14:0];
      end
    end
  end

  // Operating registers; scale rotates one place per cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      acc <= aju_pkg::WORD_ZERO;
      aux <= aju_pkg::WORD_ZERO;
      kcnt <= '0;
    end else if (state == aju_pkg::ST_EXEC) begin
      acc <= next_acc;
      aux <= next_aux;
      kcnt <= m_fld[aju_pkg::K_W-1:0];
    end else if (state == aju_pkg::ST_SCALE && !scale_done) begin
      if (op == aju_pkg::OP_NORM_ACC) begin
        acc <= acc_rot;
      end else begin
        {acc, aux} <= dbl_rot;
      end
      kcnt <= kcnt - 12'h001;
    end else if (reg_wr) begin
      if (hit_acc_lo) acc[31:0] <= wr_merged;
      if (hit_acc_hi) acc[47:32] <= wr_merged[15:0];
      if (hit_aux_lo) aux[31:0] <= wr_merged;
      if (hit_aux_hi) aux[47:32] <= wr_merged[15:0];
    end
  end

  // Index registers; scale writes back the remaining count, no shift fault flag exists
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        idx[i] <= aju_pkg::ADDR_ZERO;
      end
    end else if (state == aju_pkg::ST_SCALE && scale_done) begin
      if (des != 3'd0 && des != 3'd7) idx[des] <= {3'b000, kcnt};
    end else if (reg_wr && hit_idx) begin
      idx[bus_b] <= wr_merged[14:0];
    end
  end

  // Storage, no reset; execute writes and bus writes never meet
  always_ff @(posedge CLOCK) begin
    if (state == aju_pkg::ST_EXEC && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end else if (reg_wr && hit_mem) begin
      if (WB_ADR_I[2]) mem[bus_mi][47:32] <= wr_merged[15:0];
      else mem[bus_mi][31:0] <= wr_merged;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire ex = (state == aju_pkg::ST_EXEC);

  chk_store_acc_word: assert property (ex && op == aju_pkg::OP_STORE_ACC |=>
    mem[$past(mem_idx)] == $past(acc) && acc == $past(acc)) else $error("store acc wrong");
  chk_store_aux_word: assert property (ex && op == aju_pkg::OP_STORE_AUX |=>
    mem[$past(mem_idx)] == $past(aux) && aux == $past(aux)) else $error("store aux wrong");
  chk_acc_zero_jump: assert property (ex && op == aju_pkg::OP_ACC_JUMP && des == 3'd0
    && acc == aju_pkg::WORD_ONES |=> jump_taken && next_addr == $past(m_fld))
    else $error("neg zero jump missed");
  chk_jump_unindexed: assert property (ex && is_jump && j_cond && !des[2]
    |=> next_addr == $past(m_fld)) else $error("jump target indexed");
  chk_aux_ret_neg: assert property (ex && op == aju_pkg::OP_AUX_JUMP && des == 3'd7
    && aux[47] && aux != aju_pkg::WORD_ONES |=> next_addr == $past(m_fld) + 15'h0001)
    else $error("aux return jump wrong");
  chk_return_link: assert property (ex && is_jump && des[2] && j_cond
    |=> mem[$past(jmp_idx)][38:24] == $past(next_step)) else $error("return link lost");
  chk_mul_int_pos: assert property (ex && op == aju_pkg::OP_MUL_INT && !acc[47]
    && !operand[47] |=> {aux, acc} == 96'($past(acc)) * 96'($past(operand)))
    else $error("integer product wrong");
  chk_div_zero_ovf: assert property (ex && (op == aju_pkg::OP_DIV_INT || div_frac)
    && dsr_mag == '0 |=> div_ovf && acc == $past(acc)) else $error("divide overflow missed");
  chk_irq_follows: assert property ((div_ovf && $past(sel_ovf))
    || (range_flt && $past(sel_rng)) |-> INTERRUPT_REQ) else $error("interrupt missing");
  chk_scale_stop: assert property (state == aju_pkg::ST_SCALE && kcnt == '0 && des == 3'd1
    |=> state == aju_pkg::ST_IDLE && idx[1] == aju_pkg::ADDR_ZERO) else $error("scale overran");
  chk_scale_acc_step: assert property (state == aju_pkg::ST_SCALE && !scale_done
    && op == aju_pkg::OP_NORM_ACC |=> acc == $past(acc_rot) && kcnt == $past(kcnt) - 12'h001)
    else $error("scale step wrong");
  chk_scale_dbl_step: assert property (state == aju_pkg::ST_SCALE && !scale_done
    && op == aju_pkg::OP_NORM_DBL |=> {acc, aux} == $past(dbl_rot)) else $error("pair scale wrong");
endmodule

// *** testbench/aju_seq_model.sv ***
// Wishbone master standing in for the instruction sequencer
`timescale 1ns/1ps
module aju_seq_model (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [15:0] adr,
  output logic [31:0] wdat,
  output logic [3:0] sel
);
  // Idle bus from time zero
  initial begin
    {cyc, stb, we, adr, wdat, sel} = '0;
  end

  // One classic cycle, entered at a rising edge; held until ack is sampled
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    {cyc, stb, we} <= 3'h0;
    // Bus stays idle one cycle so the slave sees a fresh request
    @(posedge clk);
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the arithmetic, jump and scale unit
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc, stb, we, ack, irq, busy;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, r;
  logic [3:0] sel;
  logic [47:0] a, q, v, mm;
  logic [95:0] p;
  logic [11:0] k;
  int s;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] lfsr = 32'h0001_4473;

  always #2.5 clock = ~clock;

  aju_arith_jump_scale #(.MEM_WORDS(64)) dut (.CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .INTERRUPT_REQ(irq), .BUSY(busy));
  aju_seq_model seq (.clk(clock), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .wdat(wdat), .sel(sel));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [47:0] rnd();
    lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
    return {lfsr[15:0], lfsr};
  endfunction
  // Both zeros count as zero; positive means not negative
  function automatic logic taken(input logic [2:0] j, input logic [47:0] x);
    logic z;
    z = (x == 48'h0) || (x == 48'hFFFF_FFFF_FFFF);
    return j[1] ? (j[0] ^ !(x[47] && !z)) : (j[0] ^ z);
  endfunction
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a_, input logic [47:0] d);
    seq.xfer(1'b1, a_, d[31:0], r);
    seq.xfer(1'b1, a_ + 16'h0004, {16'h0000, d[47:32]}, r);
  endtask
  task automatic rd(input logic [15:0] a_, output logic [47:0] d);
    logic [31:0] lo;
    seq.xfer(1'b0, a_, 32'h0000_0000, lo);
    seq.xfer(1'b0, a_ + 16'h0004, 32'h0000_0000, r);
    d = {r[15:0], lo};
  endtask
  // Issue a command, then poll busy; the watchdog cuts a hang
  task automatic cmd(input logic [5:0] op, input logic [2:0] j, input logic [14:0] m);
    seq.xfer(1'b1, 16'h0000, {8'h00, m, j, op}, r);
    do seq.xfer(1'b0, 16'h0004, 32'h0000_0000, r); while (r[0] !== 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    a = rnd();
    q = rnd();
    wr(16'h0020, a);
    wr(16'h0028, q);
    seq.xfer(1'b1, 16'h0044, 32'h0000_0002, r);
    cmd(aju_pkg::OP_STORE_ACC, 3'h1, 15'h0003);
    cmd(aju_pkg::OP_STORE_AUX, 3'h1, 15'h0004);
    rd(16'h1028, v); check("stored acc", v, a);
    rd(16'h1030, v); check("stored aux", v, q);
    rd(16'h0020, v); check("acc kept", v, a);
    // Negative zero in the accumulator, random aux; index 1 must not offset
    wr(16'h0020, 48'hFFFF_FFFF_FFFF);
    wr(16'h000C, 48'h0123);
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? 48'hFFFF_FFFF_FFFF : q;
      cmd(i < 8 ? aju_pkg::OP_ACC_JUMP : aju_pkg::OP_AUX_JUMP, i[2:0], 15'h0010 + 15'(i));
      mm = !taken(i[2:0], v) ? 48'h0123 : 48'h0010 + 48'(i) + 48'(i[2]);
      rd(16'h0010, v); check("next address", v, mm);
      rd(16'h1080 + 16'(8 * i), v);
      if (i[2] && mm != 48'h0123) check("return link", v[38:24], 48'h0123);
    end
    // Multiply then divide back by the same operand
    for (int i = 0; i < 3; i++) begin
      a = rnd() & 48'h00FF_FFFF_FFFF;
      mm = (rnd() & 48'h000F_FFFF_FFFF) | 48'h1;
      wr(16'h0020, a);
      wr(16'h1038, mm);
      cmd(aju_pkg::OP_MUL_INT, 3'h0, 15'h0007);
      p = a * mm;
      rd(16'h0028, v); check("product high", v, p[95:48]);
      rd(16'h0020, v); check("product low", v, p[47:0]);
      cmd(aju_pkg::OP_DIV_INT, 3'h0, 15'h0007);
      rd(16'h0020, v); check("quotient", v, a);
      rd(16'h0028, v); check("remainder", v, 48'h0);
      // Fraction product sits one place higher; dividing it back returns a
      cmd(aju_pkg::OP_MUL_FRAC, 3'h0, 15'h0007);
      p = p << 1;
      rd(16'h0020, v); check("fraction high", v, p[95:48]);
      cmd(aju_pkg::OP_DIV_FRAC, 3'h0, 15'h0007);
      rd(16'h0020, v); check("fraction quotient", v, a);
    end
    // Zero divisor raises overflow and the selected interrupt
    seq.xfer(1'b1, 16'h0008, 32'h0000_0001, r);
    wr(16'h1040, 48'h0);
    cmd(aju_pkg::OP_DIV_INT, 3'h0, 15'h0008);
    check("overflow flag", 48'(r[2]), 48'h1);
    check("interrupt", 48'(irq), 48'h1);
    seq.xfer(1'b1, 16'h0004, 32'h0000_0004, r);
    check("interrupt cleared", 48'(irq), 48'h0);
    // Floating corner cases on one half held in storage word 7
    wr(16'h0020, 48'h4008_0000_0000);
    wr(16'h1038, 48'h4008_0000_0000);
    cmd(aju_pkg::OP_FLT_ADD, 3'h0, 15'h0007);
    rd(16'h0020, v); check("float sum", v, 48'h4018_0000_0000);
    rd(16'h0028, v); check("float residue", v, 48'h0);
    cmd(aju_pkg::OP_FLT_SUB, 3'h0, 15'h0007);
    rd(16'h0020, v); check("float difference", v, 48'h4008_0000_0000);
    cmd(aju_pkg::OP_FLT_MUL, 3'h0, 15'h0007);
    rd(16'h0020, v); check("float product", v, 48'h3FF8_0000_0000);
    cmd(aju_pkg::OP_FLT_DIV, 3'h0, 15'h0007);
    rd(16'h0020, v); check("float quotient", v, 48'h4008_0000_0000);
    cmd(aju_pkg::OP_FLT_DIV, 3'h0, 15'h0008);
    check("range flag", 48'(r[3]), 48'h1);
    // Scale stops at count zero or on normalisation
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 12'h00A : 12'h064;
      wr(16'h0020, i < 2 ? 48'h1 : 48'h0);
      wr(16'h0028, i < 2 ? 48'h0 : 48'h1);
      cmd(i < 2 ? aju_pkg::OP_NORM_ACC : aju_pkg::OP_NORM_DBL, 3'h1, {3'h0, k});
      check("busy", 48'(busy), 48'h0);
      s = (i == 0) ? 10 : (i == 1) ? 46 : 94;
      p = (i < 2 ? 96'h1 << 48 : 96'h1) << s;
      rd(16'h0020, v); check("scaled acc", v, p[95:48]);
      rd(16'h0028, v); check("scaled aux", v, p[47:0]);
      rd(16'h0044, v); check("count left", v[14:0], 48'(k) - 48'(s));
    end
    tally_and_finish();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule
